// *** include/uart_flow_pkg.sv ***
// constants and types for the in-band transmit flow-control block
package uart_flow_pkg;
  // ----
  // register byte offsets
  // ----
  localparam logic [7:0] ADDR_OPT2 = 8'h00; // channel_option_reg_2
  localparam logic [7:0] ADDR_OPT3 = 8'h04; // channel_option_reg_3
  localparam logic [7:0] ADDR_SC1 = 8'h08; // special_char_reg_1
  localparam logic [7:0] ADDR_SC2 = 8'h0c; // special_char_reg_2
  localparam logic [7:0] ADDR_SC3 = 8'h10; // special_char_reg_3
  localparam logic [7:0] ADDR_SC4 = 8'h14; // special_char_reg_4
  localparam logic [7:0] ADDR_CMD = 8'h18; // transmitter command
  localparam logic [7:0] ADDR_STAT = 8'h1c; // channel_control_status
  // ----
  // field positions
  // ----
  localparam int OPT2_IMPLIED = 5; // implied_resume_mode
  localparam int OPT2_IBE = 6; // tx_inband_flow_enable
  localparam int OPT3_SPECIAL_CHAR_DETECT_ENABLE = 4; // special_char_detect_enable
  localparam int OPT3_FCT = 5; // flow_char_transparency
  localparam int OPT3_OFF2 = 6; // stop_two_char_select
  localparam int OPT3_ON2 = 7; // resume_two_char_select
  localparam int CMD_TXEN = 0; // transmit enable command
  localparam int CMD_TXDIS = 1; // transmit disable command
  localparam int STAT_TXEN = 0; // transmitter enabled
  localparam int STAT_OFF = 1; // tx_flow_off_flag
  localparam int STAT_ON = 2; // tx_flow_on_flag
  // ----
  // reset values and bus answers
  // ----
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [7:0] SC_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // special status codes
  localparam logic [2:0] SPEC_NONE = 3'h0;
  localparam logic [2:0] SPEC_1 = 3'h1;
  localparam logic [2:0] SPEC_2 = 3'h2;
  localparam logic [2:0] SPEC_3 = 3'h3;
  localparam logic [2:0] SPEC_4 = 3'h4;
  // ----
  // timing: longest stop recognition time
  // ----
  localparam int CLK_MHZ = 125;
  localparam int STOP_LIMIT_US = 500;
  localparam int STOP_LIMIT_CYC = STOP_LIMIT_US * CLK_MHZ;
  // ----
  // types
  // ----
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, // no sequence open
    ST_ON1 = 3'b010, // first resume char seen
    ST_OFF1 = 3'b100 // first stop char seen
  } seq_t;
  typedef struct packed {
    logic [7:0] data; // received character
    logic err; // parity/framing/overrun error
  } rx_char_t;
  typedef struct packed {
    logic rxError; // character had an error
    logic [2:0] special; // matched special char 1..4
    logic seqFirst; // first char of pair matched
  } rx_status_t;
endpackage : uart_flow_pkg

// *** core/uart_tx_inband_flow_control.sv ***
// in-band transmit flow control with AXI4-Lite register access
// Overview of operation
// - stop character sets flow-off, halting transmitter
// - characters already loaded still finish shifting
// - detect enable compares error-free chars to four
// - flow action needs in-band enable plus detect
// - single mode: char1 resumes, char2 stops
// - pair selects: resume 1+3, stop 2+4
// - per-channel flow character definitions
// - opaque mode: act, forward char, raise exception
// - transparent mode: act, drop char silently
// - forwarded flow chars marked special 1/2
// - pair reported as second char, first-match status
// - errored second char: first becomes plain data
// - implied resume: any char resumes, unmarked, kept; errored chars here do not resume
// - otherwise only valid resume char resumes
// - transmit enable command clears flow-off
// - equal definitions toggle flow state
// - toggle: forward with special 1, or drop
// - stop sets off; resume clears off, sets on; implied resume here only clears off
// - flow-on clears when transmitter resumes sending
// - enable, disable or reset clears both flags
// - flag pair encodes stopped/resumed/running
// - gate sits between FIFO and holding register
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_inband_flow_control
  import uart_flow_pkg::*;
(
  // clock and channel reset
  input wire logic clock,
  input wire logic nrst,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // characters from the receiver
  input wire logic rxValid,
  input wire rx_char_t rxIn,
  output logic rxReady,
  // receive data and status fifo write
  output logic rfValid,
  output logic [7:0] rfData,
  output var rx_status_t rfStatus,
  output logic rxException,
  // transmit fifo to holding register
  input wire logic txFifoValid,
  input wire logic [7:0] txFifoData,
  output logic txFifoReady,
  output logic holdValid,
  output logic [7:0] holdData,
  input wire logic holdTaken
);
  // ----
  // state
  // ----
  logic [7:0] opt2, opt3, sc1, sc2, sc3, sc4; // option and char regs
  logic [7:0] next_opt2, next_opt3, next_sc1, next_sc2, next_sc3, next_sc4;
  logic awHeld, wHeld; // address / data accepted
  logic [7:0] awAddr; // held write address
  logic [31:0] wData; // held write data
  logic wLane0; // low byte lane strobe
  logic next_awHeld, next_wHeld, next_wLane0, next_bvalid, next_rvalid;
  logic [7:0] next_awAddr, next_rfData, next_holdData;
  logic [31:0] next_wData, next_rdata;
  logic [1:0] next_bresp, next_rresp;
  logic doWrite; // both halves present
  logic cmdEn, cmdDis; // command pulses
  seq_t state, next_state; // two-char sequence tracker
  logic replay, next_replay; // re-run a held char
  rx_char_t buffered, next_buffered; // char to re-run
  logic [7:0] held, next_held; // first char of a pair
  logic next_rfValid, next_rxException, next_holdValid;
  rx_status_t next_rfStatus;
  logic txEn, flowOff, flowOn; // channel_control_status
  logic next_txEn, next_flowOff, next_flowOn;
  logic evOn, evOff, evImp; // flow events this cycle
  logic txMove; // fifo to holding transfer
  // derived controls
  logic flowActive, flow_char_transparency, on2, off2, implied, toggleMode;
  rx_char_t cur; // character being judged
  logic curValid;
  // register index is unmapped when not listed
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ADDR_STAT);
  endfunction : mapped
  // ----
  // axi4-lite slave
  // ----
  // ready only while the slot is free and no response pending
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld;
  assign cmdEn = doWrite && wLane0 && awAddr == ADDR_CMD
                 && wData[CMD_TXEN];
  assign cmdDis = doWrite && wLane0 && awAddr == ADDR_CMD
                  && wData[CMD_TXDIS];
  // bus handshake and register next values
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wLane0 = wLane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_opt2 = opt2;
    next_opt3 = opt3;
    next_sc1 = sc1;
    next_sc2 = sc2;
    next_sc3 = sc3;
    next_sc4 = sc4;
    if (s_axi_awvalid && s_axi_awready) begin // address in any order
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin // data in any order
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wLane0 = s_axi_wstrb[0];
    end
    if (doWrite) begin // commit and respond
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (wLane0) begin // registers live in lane 0
        case (awAddr)
          ADDR_OPT2: next_opt2 = wData[7:0];
          ADDR_OPT3: next_opt3 = wData[7:0];
          ADDR_SC1: next_sc1 = wData[7:0];
          ADDR_SC2: next_sc2 = wData[7:0];
          ADDR_SC3: next_sc3 = wData[7:0];
          ADDR_SC4: next_sc4 = wData[7:0];
          default: ; // command, status, unmapped
        endcase
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin // read answer
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_OPT2: next_rdata = {24'h0, opt2};
        ADDR_OPT3: next_rdata = {24'h0, opt3};
        ADDR_SC1: next_rdata = {24'h0, sc1};
        ADDR_SC2: next_rdata = {24'h0, sc2};
        ADDR_SC3: next_rdata = {24'h0, sc3};
        ADDR_SC4: next_rdata = {24'h0, sc4};
        ADDR_STAT: next_rdata = {29'h0, flowOn, flowOff, txEn};
        default: next_rdata = 32'h0; // command reads zero
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end
  // bus and register flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h0;
      wLane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      opt2 <= OPT_RST;
      opt3 <= OPT_RST;
      sc1 <= SC_RST;
      sc2 <= SC_RST;
      sc3 <= SC_RST;
      sc4 <= SC_RST;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wLane0 <= next_wLane0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      opt2 <= next_opt2;
      opt3 <= next_opt3;
      sc1 <= next_sc1;
      sc2 <= next_sc2;
      sc3 <= next_sc3;
      sc4 <= next_sc4;
    end
  end
  // ----
  // receive character classification
  // ----
  assign flowActive = opt3[OPT3_SPECIAL_CHAR_DETECT_ENABLE] && opt2[OPT2_IBE];
  assign flow_char_transparency = opt3[OPT3_FCT];
  assign on2 = opt3[OPT3_ON2];
  assign off2 = opt3[OPT3_OFF2];
  assign implied = opt2[OPT2_IMPLIED];
  // equal definitions switch on toggle mode by themselves
  assign toggleMode = (sc1 == sc2) && (on2 == off2)
                      && (!on2 || sc3 == sc4);
  // a replayed char blocks new input for one cycle
  assign rxReady = !replay;
  assign cur = replay ? buffered : rxIn;
  assign curValid = replay || rxValid;

  // sequence tracking, fifo write and flow events
  always_comb begin
    next_state = state;
    next_replay = 1'b0;
    next_buffered = buffered;
    next_held = held;
    next_rfValid = 1'b0;
    next_rfData = cur.data;
    next_rfStatus = '0;
    evOn = 1'b0;
    evOff = 1'b0;
    evImp = 1'b0;
    if (curValid && state != ST_IDLE) begin
      next_state = ST_IDLE;
      if (!cur.err && ((state == ST_ON1 && cur.data == sc3)
          || (state == ST_OFF1 && cur.data == sc4))) begin
        // full pair: report second char only
        evOn = toggleMode ? flowOff : (state == ST_ON1);
        evOff = toggleMode ? !flowOff : (state == ST_OFF1);
        next_rfValid = !flow_char_transparency;
        next_rfStatus.special = (toggleMode || state == ST_ON1)
                                ? SPEC_1 : SPEC_2;
        next_rfStatus.seqFirst = 1'b1;
      end else begin
        // broken pair: first char as data, rerun second
        next_rfValid = 1'b1;
        next_rfData = held;
        next_replay = 1'b1;
        next_buffered = cur;
      end
    end else if (curValid) begin
      if (cur.err) begin // errors never match
        next_rfValid = 1'b1;
        next_rfStatus.rxError = 1'b1;
      end else if (flowActive && on2 && cur.data == sc1) begin
        next_state = ST_ON1;
        next_held = cur.data;
      end else if (flowActive && off2 && cur.data == sc2) begin
        next_state = ST_OFF1;
        next_held = cur.data;
      end else if (flowActive && cur.data == sc1) begin
        evOn = toggleMode ? flowOff : 1'b1;
        evOff = toggleMode && !flowOff;
        next_rfValid = !flow_char_transparency;
        next_rfStatus.special = SPEC_1;
      end else if (flowActive && cur.data == sc2) begin
        evOff = 1'b1;
        next_rfValid = !flow_char_transparency;
        next_rfStatus.special = SPEC_2;
      end else begin
        // ordinary or plain special-detect character
        next_rfValid = 1'b1;
        if (opt3[OPT3_SPECIAL_CHAR_DETECT_ENABLE]) begin
          if (cur.data == sc1) begin
            next_rfStatus.special = SPEC_1;
          end else if (cur.data == sc2) begin
            next_rfStatus.special = SPEC_2;
          end else if (cur.data == sc3) begin
            next_rfStatus.special = SPEC_3;
          end else if (cur.data == sc4) begin
            next_rfStatus.special = SPEC_4;
          end
        end
        // any char resumes, kept and unmarked
        evImp = flowActive && implied && flowOff;
      end
    end
    // exceptions only for entries carrying status
    next_rxException = next_rfValid && (next_rfStatus != '0);
  end
  // receive side flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= ST_IDLE;
      replay <= 1'b0;
      buffered <= '0;
      held <= 8'h00;
      rfValid <= 1'b0;
      rfData <= 8'h00;
      rfStatus <= '0;
      rxException <= 1'b0;
    end else begin
      state <= next_state;
      replay <= next_replay;
      buffered <= next_buffered;
      held <= next_held;
      rfValid <= next_rfValid;
      rfData <= next_rfData;
      rfStatus <= next_rfStatus;
      rxException <= next_rxException;
    end
  end
  // ----
  // transmit flow flags
  // ----
  // commands win over received events; a set beats the clear
  // that a resumed transfer makes in the same cycle
  always_comb begin
    next_txEn = txEn;
    next_flowOff = flowOff;
    next_flowOn = flowOn;
    if (txMove) begin
      next_flowOn = 1'b0;
    end
    if (evOff) begin
      next_flowOff = 1'b1;
      next_flowOn = 1'b0;
    end
    if (evOn) begin
      next_flowOff = 1'b0;
      next_flowOn = 1'b1;
    end
    if (evImp) begin
      next_flowOff = 1'b0;
    end
    if (cmdEn || cmdDis) begin
      next_txEn = cmdEn; // enable wins if both bits set
      next_flowOff = 1'b0;
      next_flowOn = 1'b0;
    end
  end
  // flag flops; channel reset clears both flags
  always_ff @(posedge clock) begin
    if (!nrst) begin
      txEn <= 1'b0;
      flowOff <= 1'b0;
      flowOn <= 1'b0;
    end else begin
      txEn <= next_txEn;
      flowOff <= next_flowOff;
      flowOn <= next_flowOn;
    end
  end
  // ----
  // fifo to holding register gate
  // ----
  // only the fifo side is gated; the holding register always
  // drains into the shifter, so loaded chars still go out
  assign txFifoReady = txEn && !flowOff
                       && (!holdValid || holdTaken);
  assign txMove = txFifoValid && txFifoReady;
  // holding register next value
  always_comb begin
    next_holdValid = holdValid;
    next_holdData = holdData;
    if (txMove) begin
      next_holdValid = 1'b1;
      next_holdData = txFifoData;
    end else if (holdTaken) begin
      next_holdValid = 1'b0;
    end
  end

  // holding register flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      holdValid <= 1'b0;
      holdData <= 8'h00;
    end else begin
      holdValid <= next_holdValid;
      holdData <= next_holdData;
    end
  end
endmodule : uart_tx_inband_flow_control
`default_nettype wire

// *** bench/uart_flow_sva.sv ***
// port assertions for the in-band transmit flow-control block
`timescale 1ns/1ps
`default_nettype none
module uart_flow_sva
  import uart_flow_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // receive path
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic rfValid,
  input wire rx_status_t rfStatus,
  input wire logic rxException,
  // transmit gate
  input wire logic txFifoValid,
  input wire logic [7:0] txFifoData,
  input wire logic txFifoReady,
  input wire logic holdValid,
  input wire logic [7:0] holdData,
  input wire logic holdTaken
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----
  // sequences
  // ----
  sequence txMove; // fifo head accepted by the gate
    txFifoValid && txFifoReady;
  endsequence
  sequence holdWait; // shifter still busy with the holding register
    holdValid && !holdTaken;
  endsequence
  // ----
  // assertions
  // ----
  a_gate_free: assert property (
    txFifoReady |-> !holdValid || holdTaken)
    else $error("gate open while holding register full");
  a_gate_load: assert property (
    txMove |=> holdValid && holdData == $past(txFifoData))
    else $error("holding register not loaded from fifo head");
  a_hold_drain: assert property (
    holdWait |=> holdValid && $stable(holdData))
    else $error("loaded character lost before shifter took it");
  a_exc_match: assert property (
    rfValid |-> rxException == (rfStatus != '0))
    else $error("exception does not follow status");
  a_exc_alone: assert property (
    rxException |-> rfValid)
    else $error("exception without a fifo write");
  a_err_plain: assert property (
    rfValid && rfStatus.rxError |-> rfStatus.special == SPEC_NONE)
    else $error("errored character matched a special");
  a_replay_one: assert property (
    !rxReady |=> rxReady)
    else $error("receive stall longer than one cycle");
  a_write_cause: assert property (
    rfValid |-> $past(rxValid && rxReady || !rxReady))
    else $error("fifo write without a received character");
  a_b_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_r_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule : uart_flow_sva

bind uart_tx_inband_flow_control uart_flow_sva u_sva (
  .clock(clock), .nrst(nrst), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .rxValid(rxValid), .rxReady(rxReady),
  .rfValid(rfValid), .rfStatus(rfStatus), .rxException(rxException),
  .txFifoValid(txFifoValid), .txFifoData(txFifoData),
  .txFifoReady(txFifoReady), .holdValid(holdValid),
  .holdData(holdData), .holdTaken(holdTaken)
);
`default_nettype wire

// *** bench/remote_serial_model.sv ***
// remote serial device and transmit shifter model
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model
  import uart_flow_pkg::*;
(
  // clock
  input wire logic clock,
  // characters into the receiver
  output logic rxValid,
  output var rx_char_t rxIn,
  input wire logic rxReady,
  // holding register to shifter
  input wire logic holdValid,
  output logic holdTaken
);
  // quiet line at time zero
  initial begin
    rxValid = 1'b0;
    rxIn = '0;
    holdTaken = 1'b0;
  end
  // shifter: random stall so the holding register must wait
  always @(posedge clock) begin
    holdTaken <= holdValid && !holdTaken && ($urandom_range(1) == 0);
  end
  // one character, held until taken; line then shows the inverse
  task automatic send(input rx_char_t c);
    @(posedge clock);
    rxValid <= 1'b1;
    rxIn <= c;
    do @(posedge clock); while (rxReady !== 1'b1);
    rxValid <= 1'b0;
    rxIn <= ~c;
  endtask : send
endmodule : remote_serial_model
`default_nettype wire

// *** bench/uart_tx_inband_flow_control_tb.sv ***
// self-checking bench for the in-band transmit flow-control block
`timescale 1ns/1ps
`default_nettype none
module uart_tx_inband_flow_control_tb;
  import uart_flow_pkg::*;
  // ----
  // option bits and bench state
  // ----
  localparam logic [7:0] DET = 8'h01 << OPT3_SPECIAL_CHAR_DETECT_ENABLE;
  localparam logic [7:0] TRN = 8'h01 << OPT3_FCT;
  localparam logic [7:0] OFF2 = 8'h01 << OPT3_OFF2;
  localparam logic [7:0] ON2 = 8'h01 << OPT3_ON2;
  localparam logic [7:0] IBE = 8'h01 << OPT2_IBE;
  localparam logic [7:0] IMP = 8'h01 << OPT2_IMPLIED;
  logic clock = 1'b0, nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf; // full word writes only
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rxValid, rxReady, rfValid, rxException, holdValid, holdTaken;
  rx_char_t rxIn;
  rx_status_t rfStatus;
  logic [7:0] rfData, holdData, base, sc1, sc2, sc3, sc4, ord;
  logic txFifoValid = 1'b0, txFifoReady;
  logic [7:0] txFifoData = 8'h00;
  logic [13:0] rfQ[$]; // captured fifo writes
  int fail_count = 0, check_count = 0, cycles = 0;
  // ----
  // design, far side, clock, timeout, monitor
  // ----
  uart_tx_inband_flow_control u_dut (
    .clock(clock), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rxValid(rxValid), .rxIn(rxIn), .rxReady(rxReady),
    .rfValid(rfValid), .rfData(rfData), .rfStatus(rfStatus),
    .rxException(rxException), .txFifoValid(txFifoValid),
    .txFifoData(txFifoData), .txFifoReady(txFifoReady),
    .holdValid(holdValid), .holdData(holdData), .holdTaken(holdTaken)
  );
  remote_serial_model u_remote (
    .clock(clock), .rxValid(rxValid), .rxIn(rxIn), .rxReady(rxReady),
    .holdValid(holdValid), .holdTaken(holdTaken)
  );
  always #4 clock = ~clock;
  // hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // every fifo write is kept for the scenario to judge
  always @(posedge clock) begin
    if (nrst && rfValid === 1'b1) rfQ.push_back({rfData, rfStatus, rxException});
  end
  // ----
  // expectations and bus tasks
  // ----
  function automatic logic [13:0] rfw(input logic [7:0] d,
    input logic e, input logic [2:0] s, input logic f);
    return {d, e, s, f, e | (s != SPEC_NONE) | f};
  endfunction : rfw
  function automatic logic [31:0] sw(input logic [2:0] f);
    return (32'(f[0]) << STAT_TXEN) | (32'(f[1]) << STAT_OFF) |
      (32'(f[2]) << STAT_ON);
  endfunction : sw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er = RESP_OKAY);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) aw = 1'b1;
      if (s_axi_wready === 1'b1) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er = RESP_OKAY);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // status word {on, off, enabled}
  task automatic st(input logic [2:0] f);
    rd(ADDR_STAT, sw(f));
  endtask : st
  // one received character; the write lands within three cycles
  task automatic rx(input logic [7:0] d, input logic e = 1'b0);
    u_remote.send({d, e});
    repeat (3) @(posedge clock);
  endtask : rx
  task automatic erf(input logic [7:0] d, input logic [2:0] s,
    input logic f, input logic e = 1'b0);
    logic [13:0] g;
    g = (rfQ.size() > 0) ? rfQ.pop_front() : 14'h3fff;
    chk(32'(g), 32'(rfw(d, e, s, f)));
  endtask : erf
  task automatic none;
    chk(32'(rfQ.size()), 32'h0);
  endtask : none
  // flow character or pair, forwarded with status
  task automatic flow(input logic [7:0] a, input logic [7:0] b,
    input logic two, input logic [2:0] s);
    if (two) rx(a);
    rx(two ? b : a);
    erf(two ? b : a, s, two);
  endtask : flow
  task automatic txSend(input logic [7:0] d);
    @(posedge clock);
    txFifoValid <= 1'b1;
    txFifoData <= d;
    do @(posedge clock); while (txFifoReady !== 1'b1);
    txFifoValid <= 1'b0;
  endtask : txSend
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(80801));
    base = 8'($urandom);
    sc1 = base;
    sc2 = base ^ 8'h01;
    sc3 = base ^ 8'h02;
    sc4 = base ^ 8'h04;
    ord = base ^ 8'h80;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    st(3'b000);
    rd(ADDR_OPT2, 32'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 8'h01, RESP_SLVERR);
    wr(ADDR_SC1, sc1);
    wr(ADDR_SC2, sc2);
    wr(ADDR_SC3, sc3);
    wr(ADDR_SC4, sc4);
    rd(ADDR_SC2, 32'(sc2));
    wr(ADDR_OPT3, DET);
    wr(ADDR_OPT2, IBE);
    wr(ADDR_CMD, 8'h01);
    st(3'b001);
    $display("test reset_config done");
    for (int i = 0; i < 6; i++) begin
      ord = base ^ {1'b1, 7'($urandom)};
      rx(ord);
      erf(ord, SPEC_NONE, 1'b0);
      txSend(8'($urandom));
    end
    rx(sc3);
    erf(sc3, SPEC_3, 1'b0);
    rx(sc2, 1'b1);
    erf(sc2, SPEC_NONE, 1'b0, 1'b1);
    st(3'b001);
    $display("test plain_chars done");
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_OPT3, DET | 8'(m[0]) << OPT3_OFF2 | 8'(m[1]) << OPT3_ON2);
      flow(sc2, sc4, m[0], SPEC_2);
      st(3'b011);
      if (m == 0) begin
        rx(ord);
        erf(ord, SPEC_NONE, 1'b0);
        st(3'b011);
        txFifoValid <= 1'b1;
        repeat (12) @(posedge clock);
        chk(32'(txFifoReady), 32'h0);
        chk(32'(holdValid), 32'h0);
        txFifoValid <= 1'b0;
      end
      flow(sc1, sc3, m[1], SPEC_1);
      st(3'b101);
      txSend(8'(m));
      st(3'b001);
    end
    $display("test flow_modes done");
    wr(ADDR_OPT3, DET | OFF2);
    rx(sc2);
    rx(sc4, 1'b1);
    erf(sc2, SPEC_NONE, 1'b0);
    erf(sc4, SPEC_NONE, 1'b0, 1'b1);
    st(3'b001);
    wr(ADDR_OPT3, DET | TRN);
    rx(sc2);
    none();
    st(3'b011);
    rx(sc1);
    none();
    st(3'b101);
    $display("test pair_transparent done");
    wr(ADDR_OPT2, IBE | IMP);
    rx(sc2);
    st(3'b011);
    rx(ord);
    erf(ord, SPEC_NONE, 1'b0);
    st(3'b001);
    rx(sc2);
    wr(ADDR_CMD, 8'h01);
    st(3'b001);
    rx(sc2);
    wr(ADDR_CMD, 8'h02);
    st(3'b000);
    wr(ADDR_CMD, 8'h01);
    $display("test implied_command done");
    wr(ADDR_OPT2, IBE);
    wr(ADDR_OPT3, DET);
    wr(ADDR_SC2, sc1);
    rx(sc1);
    erf(sc1, SPEC_1, 1'b0);
    st(3'b011);
    rx(sc1);
    erf(sc1, SPEC_1, 1'b0);
    st(3'b101);
    wr(ADDR_OPT3, DET | TRN);
    rx(sc1);
    none();
    st(3'b011);
    wr(ADDR_OPT3, 8'h00);
    rx(sc1);
    erf(sc1, SPEC_NONE, 1'b0);
    st(3'b011);
    wr(ADDR_OPT3, DET);
    wr(ADDR_OPT2, 8'h00);
    rx(sc1);
    erf(sc1, SPEC_1, 1'b0);
    st(3'b011);
    $display("test toggle_disabled done");
    end_sim();
  end
endmodule : uart_tx_inband_flow_control_tb
`default_nettype wire
